// ===== adcf_pkg.sv
// Contract
// - content code 00 result, 01 adds channel id
// - code 10 adds id, status, channel config
// - debug bit replaces data with 1010 0110
// - parity enable appends one parity bit
// - parity writes ignored until write unlock
// - calibration code picks range, 110/111 mean 5.0
// - margin register 19h holds 5-bit code
// - register 1ah enables the margin code
// - register 1bh holds half-reference margin setting
// - reserved bits read zero, host never writes (bench sets them with the unlock key and the 30h write)
// - parity, calibration, margin registers reset zero
// - fixed length pads to 16 or 32
// - margin enable bit 0 off, 1 on
package adcf_pkg;

	localparam logic [7:0] ADDR_UNLOCK      = 8'h00;
	localparam logic [7:0] ADDR_LENGTH_CTL  = 8'h0c;
	localparam logic [7:0] ADDR_WORD_CTL    = 8'h10;
	localparam logic [7:0] ADDR_PARITY_CTL  = 8'h11;
	localparam logic [7:0] ADDR_OFFSET_CAL  = 8'h18;
	localparam logic [7:0] ADDR_REF_MARGIN  = 8'h19;
	localparam logic [7:0] ADDR_MARGIN_EN   = 8'h1a;
	localparam logic [7:0] ADDR_HALF_MARGIN = 8'h1b;

	// writing this value opens the locked registers, anything else closes them
	localparam logic [7:0] UNLOCK_KEY = 8'haa;

	// writable-bit masks; every other bit is reserved and reads zero
	localparam logic [7:0] MASK_UNLOCK      = 8'h01;
	localparam logic [7:0] MASK_LENGTH_CTL  = 8'h01;
	localparam logic [7:0] MASK_WORD_CTL    = 8'h31;
	localparam logic [7:0] MASK_PARITY_CTL  = 8'h04;
	localparam logic [7:0] MASK_OFFSET_CAL  = 8'h07;
	localparam logic [7:0] MASK_REF_MARGIN  = 8'h1f;
	localparam logic [7:0] MASK_MARGIN_EN   = 8'h01;
	localparam logic [7:0] MASK_HALF_MARGIN = 8'h71;

	localparam int FIXED_LEN_BIT     = 0;
	localparam int CONTENT_LSB       = 4;
	localparam int DEBUG_BIT         = 0;
	localparam int PARITY_BIT        = 2;
	localparam int MARGIN_ON_BIT     = 0;
	localparam int HALF_ON_BIT       = 0;
	localparam int HALF_CODE_LSB     = 4;

	localparam logic [7:0] RESET_VALUE = 8'h00;

	typedef enum logic [1:0] {
		ADCF_FMT_RESULT = 2'h0,
		ADCF_FMT_ID     = 2'h1,
		ADCF_FMT_FULL   = 2'h2,
		ADCF_FMT_RSVD   = 2'h3
	} adcf_fmt_t;

	localparam logic [7:0] DEBUG_PATTERN = 8'ha6;
	localparam logic [5:0] DEBUG_LEN     = 6'h08;
	localparam logic [5:0] ID_BITS       = 6'h04;
	localparam logic [5:0] FULL_BITS     = 6'h0a;
	localparam logic [5:0] SHORT_FRAME   = 6'h10;
	localparam logic [5:0] LONG_FRAME    = 6'h20;
	localparam logic [2:0] RANGE_5V0     = 3'h0;

endpackage : adcf_pkg

// ===== adcf_regs.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module adcf_regs #(
	parameter int RES_W = 16
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata_q,
	input  wire logic              frame_start,
	input  wire logic [RES_W-1:0]  conv_result,
	input  wire logic [3:0]        chan_id,
	input  wire logic [3:0]        dev_status,
	input  wire logic [1:0]        chan_cfg,
	output logic                   frame_valid_q,
	output logic [31:0]            frame_word_q,
	output logic [5:0]             frame_len_q,
	output adcf_pkg::adcf_fmt_t    frame_content_q,
	output logic                   parity_on_q,
	output logic                   fixed_pattern_debug_enable_q,
	output logic                   fixed_length_output_mode_q,
	output logic [2:0]             ref_range_q,
	output logic [4:0]             reference_margin_code_q,
	output logic                   reference_margin_on_q,
	output logic [2:0]             half_reference_buffer_code_q,
	output logic                   half_reference_buffer_on_q
);
	import adcf_pkg::*;

	// 110 and 111 alias the 5.0 volt setting
	function automatic logic [2:0] norm_range(input logic [2:0] code);
		norm_range = (code[2:1] == 2'b11) ? RANGE_5V0 : code;
	endfunction : norm_range

	// data bits before parity and padding
	function automatic logic [5:0] content_len(input adcf_fmt_t fmt);
		unique case (fmt)
			ADCF_FMT_ID:   content_len = 6'(RES_W) + ID_BITS;
			ADCF_FMT_FULL: content_len = 6'(RES_W) + FULL_BITS;
			default:       content_len = 6'(RES_W);
		endcase
	endfunction : content_len

	// ---------------- register file ----------------
	logic       unlock_q, unlock_d;
	logic [7:0] length_ctl_q, length_ctl_d;
	logic [7:0] word_ctl_q, word_ctl_d;
	logic [7:0] parity_ctl_q, parity_ctl_d;
	logic [7:0] offset_cal_q, offset_cal_d;
	logic [7:0] ref_margin_q, ref_margin_d;
	logic [7:0] margin_en_q, margin_en_d;
	logic [7:0] half_margin_q, half_margin_d;
	logic [7:0] reg_rdata_d;

	always_comb begin
		unlock_d      = unlock_q;
		length_ctl_d  = length_ctl_q;
		word_ctl_d    = word_ctl_q;
		parity_ctl_d  = parity_ctl_q;
		offset_cal_d  = offset_cal_q;
		ref_margin_d  = ref_margin_q;
		margin_en_d   = margin_en_q;
		half_margin_d = half_margin_q;
		if (reg_wr) begin
			// reserved bits are masked so a stray write cannot set them
			unique case (reg_addr)
				ADDR_UNLOCK:      unlock_d = (reg_wdata == UNLOCK_KEY);
				ADDR_LENGTH_CTL:  if (unlock_q) length_ctl_d = reg_wdata & MASK_LENGTH_CTL;
				ADDR_WORD_CTL:    if (unlock_q) word_ctl_d = reg_wdata & MASK_WORD_CTL;
				ADDR_PARITY_CTL:  if (unlock_q) parity_ctl_d = reg_wdata & MASK_PARITY_CTL;
				ADDR_OFFSET_CAL:  offset_cal_d = reg_wdata & MASK_OFFSET_CAL;
				ADDR_REF_MARGIN:  ref_margin_d = reg_wdata & MASK_REF_MARGIN;
				ADDR_MARGIN_EN:   margin_en_d = reg_wdata & MASK_MARGIN_EN;
				ADDR_HALF_MARGIN: half_margin_d = reg_wdata & MASK_HALF_MARGIN;
				default: ;
			endcase
		end
		reg_rdata_d = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_UNLOCK:      reg_rdata_d = {7'h00, unlock_q};
				ADDR_LENGTH_CTL:  reg_rdata_d = length_ctl_q & MASK_LENGTH_CTL;
				ADDR_WORD_CTL:    reg_rdata_d = word_ctl_q & MASK_WORD_CTL;
				ADDR_PARITY_CTL:  reg_rdata_d = parity_ctl_q & MASK_PARITY_CTL;
				ADDR_OFFSET_CAL:  reg_rdata_d = offset_cal_q & MASK_OFFSET_CAL;
				ADDR_REF_MARGIN:  reg_rdata_d = ref_margin_q & MASK_REF_MARGIN;
				ADDR_MARGIN_EN:   reg_rdata_d = margin_en_q & MASK_MARGIN_EN;
				ADDR_HALF_MARGIN: reg_rdata_d = half_margin_q & MASK_HALF_MARGIN;
				default:          reg_rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			unlock_q      <= 1'b0;
			length_ctl_q  <= RESET_VALUE;
			word_ctl_q    <= RESET_VALUE;
			parity_ctl_q  <= RESET_VALUE;
			offset_cal_q  <= RESET_VALUE;
			ref_margin_q  <= RESET_VALUE;
			margin_en_q   <= RESET_VALUE;
			half_margin_q <= RESET_VALUE;
			reg_rdata_q   <= 8'h00;
		end else begin
			unlock_q      <= unlock_d;
			length_ctl_q  <= length_ctl_d;
			word_ctl_q    <= word_ctl_d;
			parity_ctl_q  <= parity_ctl_d;
			offset_cal_q  <= offset_cal_d;
			ref_margin_q  <= ref_margin_d;
			margin_en_q   <= margin_en_d;
			half_margin_q <= half_margin_d;
			reg_rdata_q   <= reg_rdata_d;
		end
	end

	// ---------------- analog controls ----------------
	// update in the same cycle as the registers; the analog side needs no frame sync
	logic [2:0] ref_range_d;
	logic [4:0] margin_code_d;
	logic       margin_on_d;
	logic [2:0] half_code_d;
	logic       half_on_d;

	always_comb begin
		ref_range_d   = norm_range(offset_cal_d[2:0]);
		margin_on_d   = margin_en_d[MARGIN_ON_BIT];
		// code is only passed on while margining is on
		margin_code_d = margin_on_d ? ref_margin_d[4:0] : 5'h00;
		half_on_d     = half_margin_d[HALF_ON_BIT];
		half_code_d   = half_margin_d[HALF_CODE_LSB +: 3];
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ref_range_q                  <= 3'h0;
			reference_margin_code_q      <= 5'h00;
			reference_margin_on_q        <= 1'b0;
			half_reference_buffer_code_q <= 3'h0;
			half_reference_buffer_on_q   <= 1'b0;
		end else begin
			ref_range_q                  <= ref_range_d;
			reference_margin_code_q      <= margin_code_d;
			reference_margin_on_q        <= margin_on_d;
			half_reference_buffer_code_q <= half_code_d;
			half_reference_buffer_on_q   <= half_on_d;
		end
	end

	// ---------------- frame builder ----------------
	// settings are copied only at frame_start so a frame never mixes two setups
	adcf_fmt_t   content_d;
	logic        parity_on_d;
	logic        debug_d;
	logic        fixed_d;
	logic        frame_valid_d;
	logic [31:0] frame_word_d;
	logic [5:0]  frame_len_d;
	logic [5:0]  data_len;
	logic [31:0] payload;
	logic        parity_bit;

	always_comb begin
		content_d     = frame_content_q;
		parity_on_d   = parity_on_q;
		debug_d       = fixed_pattern_debug_enable_q;
		fixed_d       = fixed_length_output_mode_q;
		frame_word_d  = frame_word_q;
		frame_len_d   = frame_len_q;
		frame_valid_d = 1'b0;
		data_len      = 6'h00;
		payload       = 32'h0;
		parity_bit    = 1'b0;
		if (frame_start) begin
			frame_valid_d = 1'b1;
			content_d     = adcf_fmt_t'(word_ctl_q[CONTENT_LSB +: 2]);
			parity_on_d   = parity_ctl_q[PARITY_BIT];
			debug_d       = word_ctl_q[DEBUG_BIT];
			fixed_d       = length_ctl_q[FIXED_LEN_BIT];
			// reserved code 11 is handled as result only
			data_len = content_len(content_d);
			payload  = 32'({conv_result, chan_id, dev_status, chan_cfg}) << (22 - RES_W);
			payload  = payload & ~(32'hffffffff >> data_len);
			parity_bit = ^payload;
			if (debug_d) begin
				frame_word_d = {DEBUG_PATTERN, 24'h0};
				data_len     = DEBUG_LEN;
			end else if (parity_on_d) begin
				frame_word_d = payload | (32'h80000000 >> data_len);
				if (!parity_bit) begin
					frame_word_d = payload;
				end
				data_len = data_len + 6'h01;
			end else begin
				frame_word_d = payload;
			end
			if (fixed_d) begin
				frame_len_d = (data_len <= SHORT_FRAME) ? SHORT_FRAME : LONG_FRAME;
			end else begin
				frame_len_d = data_len;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			frame_content_q              <= ADCF_FMT_RESULT;
			parity_on_q                  <= 1'b0;
			fixed_pattern_debug_enable_q <= 1'b0;
			fixed_length_output_mode_q   <= 1'b0;
			frame_valid_q                <= 1'b0;
			frame_word_q                 <= 32'h0;
			frame_len_q                  <= 6'h00;
		end else begin
			frame_content_q              <= content_d;
			parity_on_q                  <= parity_on_d;
			fixed_pattern_debug_enable_q <= debug_d;
			fixed_length_output_mode_q   <= fixed_d;
			frame_valid_q                <= frame_valid_d;
			frame_word_q                 <= frame_word_d;
			frame_len_q                  <= frame_len_d;
		end
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_locked_parity_write;
		!unlock_q && reg_wr && reg_addr == ADDR_PARITY_CTL;
	endsequence

	sequence s_plain_frame;
		frame_start && !word_ctl_q[DEBUG_BIT] && !length_ctl_q[FIXED_LEN_BIT];
	endsequence

	chk_parity_lock: assert property (
		s_locked_parity_write |=> $stable(parity_ctl_q))
		else $error("parity control changed while locked");

	chk_reserved_read: assert property (
		reg_rd |=> (reg_rdata_q & ~MASK_PARITY_CTL) == 8'h00
			|| $past(reg_addr) != ADDR_PARITY_CTL)
		else $error("reserved parity bits read nonzero");

	// checked on the first edge out of reset; an rst antecedent would be disabled
	chk_reset_zero: assert property (@(posedge core_clk)
		$fell(rst) |-> parity_ctl_q == 8'h00 && offset_cal_q == 8'h00 && ref_margin_q == 8'h00)
		else $error("calibration registers not zero after reset");

	chk_debug_pattern: assert property (
		frame_start && word_ctl_q[DEBUG_BIT] && !length_ctl_q[FIXED_LEN_BIT]
		|=> frame_word_q == {DEBUG_PATTERN, 24'h0} && frame_len_q == DEBUG_LEN)
		else $error("debug pattern frame wrong");

	chk_range_alias: assert property (
		offset_cal_q[2:1] == 2'b11 && $stable(offset_cal_q) |-> ref_range_q == RANGE_5V0)
		else $error("range codes 110 and 111 not mapped to 5.0");

	chk_parity_len: assert property (
		s_plain_frame ##0 (word_ctl_q[CONTENT_LSB +: 2] == 2'h0)
		|=> frame_len_q == 6'(RES_W) + 6'($past(parity_ctl_q[PARITY_BIT])))
		else $error("parity bit count wrong");

	chk_id_append: assert property (
		s_plain_frame ##0 (word_ctl_q[CONTENT_LSB +: 2] == 2'h1) && !parity_ctl_q[PARITY_BIT]
		|=> frame_len_q == 6'(RES_W) + ID_BITS)
		else $error("channel id frame length wrong");

	chk_full_frame: assert property (
		s_plain_frame ##0 (word_ctl_q[CONTENT_LSB +: 2] == 2'h2) && !parity_ctl_q[PARITY_BIT]
		|=> frame_len_q == 6'(RES_W) + FULL_BITS)
		else $error("full frame length wrong");

	chk_fixed_pad: assert property (
		frame_valid_q && fixed_length_output_mode_q
		|-> frame_len_q == SHORT_FRAME || frame_len_q == LONG_FRAME)
		else $error("fixed length frame not padded");

	chk_frame_hold: assert property (
		!frame_start |=> $stable(frame_content_q) && $stable(parity_on_q)
			&& $stable(fixed_pattern_debug_enable_q))
		else $error("frame settings changed mid frame");

	chk_margin_gate: assert property (
		!margin_en_q[MARGIN_ON_BIT] ##1 !margin_en_q[MARGIN_ON_BIT]
		|-> reference_margin_code_q == 5'h00 && !reference_margin_on_q)
		else $error("margin applied while disabled");

endmodule : adcf_regs
`default_nettype wire

// ===== adcf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcf_host_model (
	input  wire logic       core_clk,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata_q
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// callers keep reserved bits clear apart from the unlock key and the 30h write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// released lines flip so a stale value cannot pass for a live one
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata_q;
		@(posedge core_clk);
	endtask : rd
endmodule : adcf_host_model
`default_nettype wire

// ===== tb_adc_output_format_cal_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_adc_output_format_cal_regs;
	import adcf_pkg::*;
	logic        core_clk;
	logic        rst;
	logic        frame_start;
	logic [15:0] conv_result;
	logic [3:0]  chan_id;
	logic [3:0]  dev_status;
	logic [1:0]  chan_cfg;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata_q;
	logic        reg_wr, reg_rd, frame_valid_q, parity_on_q, dbg_q, fix_q;
	logic [31:0] frame_word_q;
	logic [5:0]  frame_len_q;
	adcf_fmt_t   frame_content_q;
	logic [2:0]  ref_range_q, half_code_q;
	logic [4:0]  margin_code_q;
	logic        margin_on_q, half_on_q;
	logic [7:0]  regs [8];
	int          err_count, checks;

	adcf_regs adcf_regs_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.frame_start(frame_start), .conv_result(conv_result), .chan_id(chan_id),
		.dev_status(dev_status), .chan_cfg(chan_cfg), .frame_valid_q(frame_valid_q),
		.frame_word_q(frame_word_q), .frame_len_q(frame_len_q),
		.frame_content_q(frame_content_q), .parity_on_q(parity_on_q),
		.fixed_pattern_debug_enable_q(dbg_q), .fixed_length_output_mode_q(fix_q),
		.ref_range_q(ref_range_q), .reference_margin_code_q(margin_code_q),
		.reference_margin_on_q(margin_on_q), .half_reference_buffer_code_q(half_code_q),
		.half_reference_buffer_on_q(half_on_q));
	adcf_host_model adcf_host_model_i (.core_clk(core_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		adcf_host_model_i.wr(a, d);
	endtask : w
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		adcf_host_model_i.rd(a, v);
		chk("register read", v, e);
	endtask : rchk
	task automatic cfg(input logic [1:0] f, input logic p, input logic d, input logic x);
		w(ADDR_WORD_CTL, {2'h0, f, 3'h0, d});
		w(ADDR_PARITY_CTL, {5'h0, p, 2'h0});
		w(ADDR_LENGTH_CTL, {7'h0, x});
	endtask : cfg
	task automatic frame(input logic [1:0] f, input logic p, input logic d, input logic x);
		logic [31:0] v;
		int          n;
		v = (f == 2'h1) ? {conv_result, chan_id, 12'h0} :
			(f == 2'h2) ? {conv_result, chan_id, dev_status, chan_cfg, 6'h0} :
			{conv_result, 16'h0};
		n = (f == 2'h1) ? 20 : (f == 2'h2) ? 26 : 16;
		if (p) begin
			v[31 - n] = ^v;
			n++;
		end
		if (d) begin
			v = {DEBUG_PATTERN, 24'h0};
			n = 8;
		end
		if (x)
			n = (n <= 16) ? 16 : 32;
		frame_start <= 1'b1;
		@(posedge core_clk);
		frame_start <= 1'b0;
		#1 chk("frame valid", frame_valid_q, 32'h1);
		chk("frame word", frame_word_q, v);
		chk("frame length", frame_len_q, n);
		chk("frame content", frame_content_q, f);
		chk("parity on", parity_on_q, p);
		chk("debug on", dbg_q, d);
		chk("fixed on", fix_q, x);
		@(posedge core_clk);
	endtask : frame

	initial begin
		rst = 1'b1;
		frame_start = 1'b0;
		conv_result = 16'hc35a;
		chan_id = 4'h9;
		dev_status = 4'h6;
		chan_cfg = 2'h2;
		err_count = 0;
		checks = 0;
		regs = '{ADDR_UNLOCK, ADDR_LENGTH_CTL, ADDR_WORD_CTL, ADDR_PARITY_CTL,
			ADDR_OFFSET_CAL, ADDR_REF_MARGIN, ADDR_MARGIN_EN, ADDR_HALF_MARGIN};
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 8; i++)
			rchk(regs[i], RESET_VALUE);
		w(ADDR_PARITY_CTL, 8'h04);
		w(ADDR_WORD_CTL, 8'h10);
		rchk(ADDR_PARITY_CTL, 8'h00);
		frame(2'h0, 1'b0, 1'b0, 1'b0);
		w(ADDR_UNLOCK, UNLOCK_KEY);
		rchk(ADDR_UNLOCK, 8'h01);
		// every legal content code, with and without parity, free and fixed length
		for (int x = 0; x < 2; x++)
			for (int p = 0; p < 2; p++)
				for (int f = 0; f < 3; f++) begin
					cfg(2'(f), 1'(p), 1'b0, 1'(x));
					frame(2'(f), 1'(p), 1'b0, 1'(x));
				end
		rchk(ADDR_PARITY_CTL, 8'h04);
		for (int x = 0; x < 2; x++) begin
			cfg(2'h0, 1'b0, 1'b1, 1'(x));
			frame(2'h0, 1'b0, 1'b1, 1'(x));
		end
		cfg(2'h0, 1'b0, 1'b0, 1'b0);
		frame(2'h0, 1'b0, 1'b0, 1'b0);
		w(ADDR_WORD_CTL, 8'h10);
		rchk(ADDR_WORD_CTL, 8'h10);
		chk("held length", frame_len_q, 32'd16);
		chk("held content", frame_content_q, 32'h0);
		frame(2'h1, 1'b0, 1'b0, 1'b0);
		w(ADDR_UNLOCK, 8'h00);
		w(ADDR_PARITY_CTL, 8'h04);
		rchk(ADDR_PARITY_CTL, 8'h00);
		for (int c = 0; c < 8; c++) begin
			w(ADDR_OFFSET_CAL, 8'(c));
			rchk(ADDR_OFFSET_CAL, 8'(c));
			chk("range", ref_range_q, (c >= 6) ? 0 : c);
		end
		w(ADDR_REF_MARGIN, 8'h15);
		rchk(ADDR_REF_MARGIN, 8'h15);
		chk("margin code off", margin_code_q, 32'h0);
		chk("margin off", margin_on_q, 32'h0);
		w(ADDR_MARGIN_EN, 8'h01);
		rchk(ADDR_MARGIN_EN, 8'h01);
		chk("margin code on", margin_code_q, 32'h15);
		chk("margin on", margin_on_q, 32'h1);
		w(ADDR_HALF_MARGIN, 8'h51);
		rchk(ADDR_HALF_MARGIN, 8'h51);
		chk("half code", half_code_q, 32'h5);
		chk("half on", half_on_q, 32'h1);
		w(8'h30, 8'h01);
		rchk(8'h30, 8'h00);
		// mid-run reset with word, calibration and margin registers nonzero
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 8; i++)
			rchk(regs[i], RESET_VALUE);
		chk("range after reset", ref_range_q, 32'h0);
		chk("margin code after reset", margin_code_q, 32'h0);
		chk("margin on after reset", margin_on_q, 32'h0);
		results();
	end
endmodule : tb_adc_output_format_cal_regs
`default_nettype wire
